//--- verilog/cte_pkg.sv
// Purpose: Shared constants of the timer event and output control block
// Assumes: 8-bit byte address, 32-bit register data
// Notes: Each register sits at its own byte offset on the bus

package cte_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_WO = 8;
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DBG_W = 8;
  localparam int STS_W = 3;

  // ==========================================================
  // Register indices and byte addresses
  localparam logic [ADDR_W-1:0] IDX_DRV = 8'h18;
  localparam logic [ADDR_W-1:0] IDX_DBG = 8'h1E;
  localparam logic [ADDR_W-1:0] IDX_EV = 8'h20;
  localparam logic [ADDR_W-1:0] IDX_IEC = 8'h24;
  localparam logic [ADDR_W-1:0] IDX_IES = 8'h28;
  localparam logic [ADDR_W-1:0] IDX_STS = 8'h2C;
  localparam logic [ADDR_W-1:0] ADDR_DRV = IDX_DRV;
  localparam logic [ADDR_W-1:0] ADDR_DBG = IDX_DBG;
  localparam logic [ADDR_W-1:0] ADDR_EV = IDX_EV;
  localparam logic [ADDR_W-1:0] ADDR_IEC = IDX_IEC;
  localparam logic [ADDR_W-1:0] ADDR_IES = IDX_IES;
  localparam logic [ADDR_W-1:0] ADDR_STS = IDX_STS;

  // ==========================================================
  // Reset values and writable masks
  localparam logic [DATA_W-1:0] DRV_RST = 32'h0000_0000;
  localparam logic [DBG_W-1:0] DBG_RST = 8'h00;
  localparam logic [DBG_W-1:0] DBG_MASK = 8'h05;
  localparam logic [DATA_W-1:0] EV_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] EV_MASK = 32'h0F0F_F7FF;
  localparam logic [DATA_W-1:0] IEN_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] IEN_MASK = 32'h000F_FC0F;
  localparam logic [STS_W-1:0] STS_RST = 3'h0;

  // ==========================================================
  // Field positions
  localparam int DRV_NRE_LSB = 0;
  localparam int DRV_NRV_LSB = 8;
  localparam int DRV_INV_LSB = 16;
  localparam int DBG_RUN_BIT = 0;
  localparam int DBG_FDD_BIT = 2;
  localparam int EV_ACT0_LSB = 0;
  localparam int EV_ACT1_LSB = 3;
  localparam int EV_SEL_LSB = 6;
  localparam int EV_OVF_BIT = 8;
  localparam int EV_TRG_BIT = 9;
  localparam int EV_CNT_BIT = 10;
  localparam int EV_INV_LSB = 12;
  localparam int EV_TEI_LSB = 14;
  localparam int EV_CHANNEL_EVENT_IN_ENABLE_LSB = 16;
  localparam int EV_CHANNEL_EVENT_OUT_ENABLE_LSB = 24;
  localparam int IEN_MC_LSB = 16;
  localparam int IEN_FLT0_BIT = 14;
  localparam int IEN_FLT1_BIT = 15;
  localparam int STS_FLT0_BIT = 0;
  localparam int STS_FLT1_BIT = 1;
  localparam int STS_DFLT_BIT = 2;

  // ==========================================================
  // Event actions and cycle points
  localparam logic [2:0] ACT_OFF = 3'h0;
  localparam logic [2:0] ACT_RETRIG = 3'h1;
  localparam logic [2:0] ACT0_COUNT_ON_EVENT = 3'h2;
  localparam logic [2:0] ACT0_START = 3'h3;
  localparam logic [2:0] ACT0_INC = 3'h4;
  localparam logic [2:0] ACT0_COUNT = 3'h5;
  localparam logic [2:0] ACT1_DIR = 3'h2;
  localparam logic [2:0] ACT1_STOP = 3'h3;
  localparam logic [2:0] ACT1_DEC = 3'h4;
  localparam logic [2:0] ACT1_PPW = 3'h5;
  localparam logic [2:0] ACT1_PWP = 3'h6;
  localparam logic [2:0] ACT_FAULT = 3'h7;
  localparam logic [1:0] SEL_BEGIN = 2'h0;
  localparam logic [1:0] SEL_END = 2'h1;
  localparam logic [1:0] SEL_BETWEEN = 2'h2;
  localparam logic [1:0] SEL_BOUNDARY = 2'h3;

endpackage

//--- verilog/cte_wave_if.sv
// Purpose: Carries waveform data and fault override to the output stage
// Assumes: One clock domain
// Notes: Pin level and enable return registered

`timescale 1ns/1ps

interface cte_wave_if;
  import cte_pkg::*;
  logic [NUM_WO-1:0] wave;
  logic [NUM_WO-1:0] invert;
  logic [NUM_WO-1:0] fault_val;
  logic [NUM_WO-1:0] fault_ovr;
  logic fault;
  logic [NUM_WO-1:0] pin;
  logic [NUM_WO-1:0] pin_oe;
  modport ctl (output wave, invert, fault_val, fault_ovr, fault,
               input pin, pin_oe);
  modport stage (input wave, invert, fault_val, fault_ovr, fault,
                 output pin, pin_oe);
endinterface

//--- verilog/cte_out_stage.sv
// Purpose: Waveform output inversion and fault override stage
// Assumes: Fault level is already latched upstream
// Notes: One cycle of latency from waveform to pin

`timescale 1ns/1ps

module cte_out_stage
  import cte_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Waveform carrier
  cte_wave_if.stage wif
);

  // ==========================================================
  // Output selection
  logic [NUM_WO-1:0] next_pin;
  logic [NUM_WO-1:0] next_oe;

  assign next_pin = wif.fault ? wif.fault_val
                              : (wif.wave ^ wif.invert);
  // Without override a fault floats the pin
  assign next_oe = wif.fault ? wif.fault_ovr : {NUM_WO{1'b1}};

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wif.pin <= '0;
      wif.pin_oe <= '0;
    end else begin
      wif.pin <= next_pin;
      wif.pin_oe <= next_oe;
    end
  end

  // ==========================================================
  // Checks
  chk_wave_invert: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !wif.fault |=> wif.pin == ($past(wif.wave) ^ $past(wif.invert)))
    else $error("Output inversion wrong");
  chk_fault_level: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    wif.fault |=> ((wif.pin ^ $past(wif.fault_val)) & wif.pin_oe) == '0)
    else $error("Fault override level wrong");
  chk_fault_float: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    wif.fault |=> wif.pin_oe == $past(wif.fault_ovr))
    else $error("Fault tri-state wrong");

endmodule

//--- verilog/cte_event_ctrl.sv
// Purpose: Event, debug, driver and interrupt-enable control of a timer
// Assumes: Counter core supplies cycle, wrap, retrigger and match strobes
// Notes: Fault flags latch until cleared by software or soft reset
//
// Contract
// - Invert bit flips each waveform output
// - Fault drives enabled outputs to fault value
// - Override off tri-states, on forces value
// - Debug halt with fault enable raises fault
// - Timer halts in debug unless run set
// - Debug bits survive soft reset
// - Channel match emits event when enabled
// - Channel input events gated by enable
// - Timer event inputs ignored unless enabled
// - Invert bit inverts timer event input
// - Cycle event emitted only when enabled
// - Retrigger event emitted when enabled
// - Wrap event on top or zero
// - Cycle select picks begin, end, between, boundary
// - Input one action decode
// - Input zero action decode
// - Clear register disables channel interrupts
// - Clear register disables fault interrupts
// - Set and clear share one enable

`timescale 1ns/1ps

module cte_event_ctrl
  import cte_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_soft_reset,
  // Register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  // Protection
  input wire logic i_wr_protect,
  input wire logic i_timer_enabled,
  // Debug
  input wire logic i_debug_halt,
  output logic o_timer_halt,
  // Event inputs
  input wire logic [1:0] i_tev,
  input wire logic [NUM_CH-1:0] i_ch_ev_in,
  output logic [NUM_CH-1:0] o_ch_ev_accept,
  // Counter status
  input wire logic i_cyc_begin,
  input wire logic i_cyc_end,
  input wire logic i_first_cycle,
  input wire logic i_last_cycle,
  input wire logic i_retrigger,
  input wire logic i_wrap,
  input wire logic [NUM_CH-1:0] i_cc_match,
  // Event outputs
  output logic o_cycle_ev,
  output logic o_cycle_point,
  output logic o_retrig_ev,
  output logic o_wrap_ev,
  output logic [NUM_CH-1:0] o_ch_ev_out,
  // Counter commands
  output logic o_cmd_retrigger,
  output logic o_cmd_start,
  output logic o_cmd_stop,
  output logic o_cmd_count_event,
  output logic o_cmd_count_gate,
  output logic o_cmd_step_up,
  output logic o_cmd_step_down,
  output logic o_cmd_dir_down,
  output logic o_cmd_ppw,
  output logic o_cmd_pwp,
  // Fault and interrupt enables
  output logic o_fault_state,
  output logic [DATA_W-1:0] o_irq_enable,
  // Waveform outputs
  input wire logic [NUM_WO-1:0] i_wave,
  output logic [NUM_WO-1:0] o_wave,
  output logic [NUM_WO-1:0] o_wave_oe
);

  // ==========================================================
  // Helpers
  function automatic logic ev_cond(input logic raw, input logic inv,
                                   input logic en);
    return en & (raw ^ inv);
  endfunction

  // ==========================================================
  // Registers
  logic [DATA_W-1:0] drv;
  logic [DBG_W-1:0] dbg;
  logic [DATA_W-1:0] ev;
  logic [DATA_W-1:0] ien;
  logic [STS_W-1:0] sts;

  // ==========================================================
  // Address decode and write qualification
  logic sel_drv, sel_dbg, sel_ev, sel_iec, sel_ies, sel_sts;
  logic wr_ok, ep_ok;

  assign sel_drv = i_addr == ADDR_DRV;
  assign sel_dbg = i_addr == ADDR_DBG;
  assign sel_ev = i_addr == ADDR_EV;
  assign sel_iec = i_addr == ADDR_IEC;
  assign sel_ies = i_addr == ADDR_IES;
  assign sel_sts = i_addr == ADDR_STS;
  assign wr_ok = i_wr && !i_wr_protect;
  // Enable-protected registers also lock while the timer runs
  assign ep_ok = wr_ok && !i_timer_enabled;

  // ==========================================================
  // Field views
  logic [2:0] act0, act1;
  logic [1:0] cyc_sel;
  logic [NUM_CH-1:0] channel_event_in_enable, channel_event_out_enable;
  logic tev0, tev1;

  assign act0 = ev[EV_ACT0_LSB +: 3];
  assign act1 = ev[EV_ACT1_LSB +: 3];
  assign cyc_sel = ev[EV_SEL_LSB +: 2];
  assign channel_event_in_enable = ev[EV_CHANNEL_EVENT_IN_ENABLE_LSB +: NUM_CH];
  assign channel_event_out_enable = ev[EV_CHANNEL_EVENT_OUT_ENABLE_LSB +: NUM_CH];
  assign tev0 = ev_cond(i_tev[0], ev[EV_INV_LSB],
                        ev[EV_TEI_LSB]);
  assign tev1 = ev_cond(i_tev[1], ev[EV_INV_LSB+1],
                        ev[EV_TEI_LSB+1]);

  // ==========================================================
  // Next register values
  logic [DATA_W-1:0] next_drv, next_ev, next_ien, ien_set, ien_clr;
  logic [DBG_W-1:0] next_dbg;
  logic [STS_W-1:0] next_sts, sts_set, sts_clr;

  assign next_drv = (ep_ok && sel_drv) ? i_wdata : drv;
  assign next_ev = (ep_ok && sel_ev) ? (i_wdata & EV_MASK) : ev;
  assign next_dbg = (wr_ok && sel_dbg) ? (i_wdata[DBG_W-1:0] & DBG_MASK)
                                       : dbg;
  assign ien_set = (wr_ok && sel_ies) ? (i_wdata & IEN_MASK) : '0;
  assign ien_clr = (wr_ok && sel_iec) ? (i_wdata & IEN_MASK) : '0;
  // One enable state behind both views
  assign next_ien = (ien | ien_set) & ~ien_clr;
  assign sts_set[STS_FLT0_BIT] = tev0 && act0 == ACT_FAULT;
  assign sts_set[STS_FLT1_BIT] = tev1 && act1 == ACT_FAULT;
  assign sts_set[STS_DFLT_BIT] = i_debug_halt && dbg[DBG_FDD_BIT];
  assign sts_clr = (wr_ok && sel_sts) ? i_wdata[STS_W-1:0] : '0;
  // A fault arriving with its clear is kept
  assign next_sts = (sts & ~sts_clr) | sts_set;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      dbg <= DBG_RST;
    end else begin
      dbg <= next_dbg;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst || i_soft_reset) begin
      drv <= DRV_RST;
      ev <= EV_RST;
      ien <= IEN_RST;
      sts <= STS_RST;
    end else begin
      drv <= next_drv;
      ev <= next_ev;
      ien <= next_ien;
      sts <= next_sts;
    end
  end

  // ==========================================================
  // Event outputs and commands
  logic cyc_point;
  logic [2:0] next_misc;
  logic [9:0] next_cmd;

  always_comb begin
    if (cyc_sel == SEL_BEGIN) begin
      cyc_point = i_cyc_begin;
    end else if (cyc_sel == SEL_END) begin
      cyc_point = i_cyc_end;
    end else if (cyc_sel == SEL_BETWEEN) begin
      cyc_point = i_cyc_end && !i_last_cycle;
    end else begin
      cyc_point = (i_cyc_begin && i_first_cycle) ||
                  (i_cyc_end && i_last_cycle);
    end
  end

  assign next_misc[0] = cyc_point && ev[EV_CNT_BIT];
  assign next_misc[1] = i_retrigger && ev[EV_TRG_BIT];
  assign next_misc[2] = i_wrap && ev[EV_OVF_BIT];
  assign next_cmd[0] = (tev0 && act0 == ACT_RETRIG) ||
                       (tev1 && act1 == ACT_RETRIG);
  assign next_cmd[1] = tev0 && act0 == ACT0_START;
  assign next_cmd[2] = tev1 && act1 == ACT1_STOP;
  assign next_cmd[3] = tev0 && act0 == ACT0_COUNT_ON_EVENT;
  // Gate follows the live input level
  assign next_cmd[4] = tev0 && act0 == ACT0_COUNT;
  assign next_cmd[5] = tev0 && act0 == ACT0_INC;
  assign next_cmd[6] = tev1 && act1 == ACT1_DEC;
  assign next_cmd[7] = tev1 && act1 == ACT1_DIR;
  assign next_cmd[8] = tev1 && act1 == ACT1_PPW;
  assign next_cmd[9] = tev1 && act1 == ACT1_PWP;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      {o_wrap_ev, o_retrig_ev, o_cycle_ev} <= '0;
      {o_cmd_pwp, o_cmd_ppw, o_cmd_dir_down, o_cmd_step_down,
       o_cmd_step_up, o_cmd_count_gate, o_cmd_count_event,
       o_cmd_stop, o_cmd_start, o_cmd_retrigger} <= '0;
      o_cycle_point <= 1'b0;
      o_ch_ev_out <= '0;
      o_ch_ev_accept <= '0;
      o_timer_halt <= 1'b0;
    end else begin
      {o_wrap_ev, o_retrig_ev, o_cycle_ev} <= next_misc;
      {o_cmd_pwp, o_cmd_ppw, o_cmd_dir_down, o_cmd_step_down,
       o_cmd_step_up, o_cmd_count_gate, o_cmd_count_event,
       o_cmd_stop, o_cmd_start, o_cmd_retrigger} <= next_cmd;
      o_cycle_point <= cyc_point;
      o_ch_ev_out <= i_cc_match & channel_event_out_enable;
      o_ch_ev_accept <= i_ch_ev_in & channel_event_in_enable;
      o_timer_halt <= i_debug_halt && !dbg[DBG_RUN_BIT];
    end
  end

  assign o_fault_state = |sts;
  assign o_irq_enable = ien;

  // ==========================================================
  // Read-back, data one cycle after the strobe
  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    if (!i_rd) begin
      rd_mux = '0;
    end else if (sel_drv) begin
      rd_mux = drv;
    end else if (sel_dbg) begin
      rd_mux = {{(DATA_W-DBG_W){1'b0}}, dbg};
    end else if (sel_ev) begin
      rd_mux = ev;
    end else if (sel_iec || sel_ies) begin
      rd_mux = ien;
    end else if (sel_sts) begin
      rd_mux = {{(DATA_W-STS_W){1'b0}}, sts};
    end else begin
      rd_mux = '0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= rd_mux;
    end
  end

  // ==========================================================
  // Output stage
  cte_wave_if wif ();

  assign wif.wave = i_wave;
  assign wif.invert = drv[DRV_INV_LSB +: NUM_WO];
  assign wif.fault_val = drv[DRV_NRV_LSB +: NUM_WO];
  assign wif.fault_ovr = drv[DRV_NRE_LSB +: NUM_WO];
  assign wif.fault = o_fault_state;
  assign o_wave = wif.pin;
  assign o_wave_oe = wif.pin_oe;

  cte_out_stage u_stage (
    .i_sys_clk (i_sys_clk),
    .i_rst (i_rst),
    .wif (wif.stage)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  chk_debug_halt: assert property (
    i_debug_halt && !dbg[DBG_RUN_BIT] |=> o_timer_halt ##1 1'b1)
    else $error("Timer not halted in debug");
  chk_debug_run: assert property (
    !i_debug_halt || dbg[DBG_RUN_BIT] |=> !o_timer_halt)
    else $error("Timer halted while run in debug set");
  chk_debug_fault: assert property (
    i_debug_halt && dbg[DBG_FDD_BIT] |=> o_fault_state
      ##1 (o_wave_oe == $past(drv[DRV_NRE_LSB +: NUM_WO])))
    else $error("Debug break fault not raised");
  chk_debug_keep: assert property (
    i_soft_reset && !(i_wr && sel_dbg) |=> dbg == $past(dbg))
    else $error("Debug bits lost on soft reset");
  chk_chan_out: assert property (
    |(i_cc_match & ~channel_event_out_enable) |=>
      (o_ch_ev_out & ~$past(channel_event_out_enable)) == '0)
    else $error("Disabled channel event emitted");
  chk_chan_in: assert property (
    1'b1 |=> (o_ch_ev_accept & ~$past(channel_event_in_enable)) == '0)
    else $error("Disabled channel input accepted");
  chk_tev_ignore: assert property (
    ev[EV_TEI_LSB +: 2] == 2'b00 |=>
      !o_cmd_retrigger && !o_cmd_start && !o_cmd_stop)
    else $error("Disabled timer event acted on");
  chk_tev_invert: assert property (
    ev[EV_TEI_LSB] && ev[EV_INV_LSB] && act0 == ACT_RETRIG && !i_tev[0]
      |=> o_cmd_retrigger)
    else $error("Inverted event not acted on");
  chk_cycle_begin: assert property (
    ev[EV_CNT_BIT] && cyc_sel == SEL_BEGIN && i_cyc_begin
      |=> o_cycle_ev)
    else $error("Cycle event missing");
  chk_cycle_off: assert property (
    !ev[EV_CNT_BIT] |=> !o_cycle_ev)
    else $error("Cycle event while disabled");
  chk_retrig_ev: assert property (
    i_retrigger && ev[EV_TRG_BIT] |=> o_retrig_ev)
    else $error("Retrigger event missing");
  chk_wrap_ev: assert property (
    i_wrap |=> o_wrap_ev == $past(ev[EV_OVF_BIT]))
    else $error("Wrap event wrong");
  chk_act1_decode: assert property (
    tev1 && act1 == ACT1_PPW |=> o_cmd_ppw && !o_cmd_pwp)
    else $error("Input one action wrong");
  chk_act0_decode: assert property (
    tev0 && act0 == ACT0_INC |=> o_cmd_step_up)
    else $error("Input zero action wrong");
  chk_ien_clear: assert property (
    wr_ok && sel_iec && i_wdata[IEN_MC_LSB] && !i_soft_reset
      |=> !o_irq_enable[IEN_MC_LSB])
    else $error("Channel interrupt enable not cleared");
  chk_flt_clear: assert property (
    wr_ok && sel_iec && !i_wdata[IEN_FLT1_BIT] && !i_soft_reset
      |=> o_irq_enable[IEN_FLT1_BIT] == $past(ien[IEN_FLT1_BIT]))
    else $error("Zero write changed fault enable");
  chk_ien_shared: assert property (
    wr_ok && sel_ies && i_wdata[IEN_FLT0_BIT] && !i_soft_reset
      ##1 i_rd && sel_iec && !i_soft_reset |=> o_rdata[IEN_FLT0_BIT])
    else $error("Set not visible through clear view");
  chk_protect: assert property (
    i_wr && (i_wr_protect || i_timer_enabled) && sel_ev && !i_soft_reset
      |=> $stable(ev))
    else $error("Protected write took effect");

  cov_debug_fault: cover property (i_debug_halt && dbg[DBG_FDD_BIT]);
  cov_ien_round: cover property (
    wr_ok && sel_ies ##1 wr_ok && sel_iec);
  cov_ppw: cover property (tev1 && act1 == ACT1_PPW);
  cov_boundary: cover property (
    cyc_sel == SEL_BOUNDARY && ev[EV_CNT_BIT] && cyc_point);

endmodule

//--- dv/cte_fabric_model.sv
// Purpose: Event fabric and pad model at the block's far side
// Assumes: Events are routed with no delay
// Notes: No pull on the pads, so an undriven pad keeps changing
`timescale 1ns/1ps
module cte_fabric_model
  import cte_pkg::*;
(
  // Clock
  input wire logic i_sys_clk,
  // Requests from the bench
  input wire logic [1:0] i_tev_req,
  input wire logic [NUM_CH-1:0] i_ch_req,
  // Block side
  input wire logic [NUM_WO-1:0] i_pin,
  input wire logic [NUM_WO-1:0] i_pin_oe,
  output logic [1:0] o_tev,
  output logic [NUM_CH-1:0] o_ch_ev,
  output logic [NUM_WO-1:0] o_pad
);
  logic [NUM_WO-1:0] flip = 8'h00;
  // ======
  // Routing
  assign o_tev = i_tev_req;
  assign o_ch_ev = i_ch_req;
  // ======
  // Pads
  // A floating pad must never look like a held level
  always @(posedge i_sys_clk) begin
    flip <= ~flip;
  end
  assign o_pad = (i_pin & i_pin_oe) | (flip & ~i_pin_oe);
endmodule

//--- dv/cte_event_ctrl_bench.sv
// Purpose: Self-checking bench of the timer event control block
// Assumes: One 10 MHz clock, sync reset held 20 cycles
// Notes: Drivers queue expected results, a monitor checks them
`timescale 1ns/1ps
module cte_event_ctrl_bench;
  import cte_pkg::*;
  // ======
  // Stimulus and model state
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_soft_reset = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_wr_protect = 1'b0;
  logic i_timer_enabled = 1'b0;
  logic i_debug_halt = 1'b0;
  logic [1:0] tev_req = 2'h0;
  logic [3:0] ch_req = 4'h0;
  logic [3:0] i_cc_match = 4'h0;
  logic [5:0] cst = 6'h00;
  logic [7:0] i_wave = 8'h00;
  logic chk = 1'b0;
  logic chk_d = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] ra_d = 8'h00;
  logic [31:0] m_drv = 32'h0000_0000;
  logic [31:0] m_ev = 32'h0000_0000;
  logic [31:0] ev_r;
  logic [7:0] m_dbg = 8'h00;
  logic flt = 1'b0;
  logic [31:0] rq[$];
  logic [39:0] eq[$];
  logic [39:0] mq[$];
  int failures = 0;
  int compares = 0;
  logic [31:0] o_rdata;
  logic [31:0] o_irq_enable;
  logic [7:0] o_wave, o_wave_oe;
  logic [3:0] o_ch_ev_out, o_ch_ev_accept, ch_ev;
  logic [1:0] tev;
  logic [9:0] cmd;
  logic o_timer_halt, o_cycle_ev, o_cycle_point, o_retrig_ev, o_wrap_ev;
  logic o_fault_state;
  logic [39:0] got;
  assign got = {o_wave, o_wave_oe, o_ch_ev_out, o_ch_ev_accept, o_cycle_ev,
    o_cycle_point, o_retrig_ev, o_wrap_ev, o_timer_halt, o_fault_state, cmd};

  initial begin
    forever #50 i_sys_clk = ~i_sys_clk;
  end

  cte_fabric_model fab (.i_sys_clk(i_sys_clk), .i_tev_req(tev_req),
    .i_ch_req(ch_req), .i_pin(o_wave), .i_pin_oe(o_wave_oe), .o_tev(tev),
    .o_ch_ev(ch_ev), .o_pad());

  cte_event_ctrl dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_soft_reset(i_soft_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_wr_protect(i_wr_protect), .i_timer_enabled(i_timer_enabled),
    .i_debug_halt(i_debug_halt), .o_timer_halt(o_timer_halt),
    .i_tev(tev), .i_ch_ev_in(ch_ev), .o_ch_ev_accept(o_ch_ev_accept),
    .i_cyc_begin(cst[5]), .i_cyc_end(cst[4]), .i_first_cycle(cst[3]),
    .i_last_cycle(cst[2]), .i_retrigger(cst[1]), .i_wrap(cst[0]),
    .i_cc_match(i_cc_match), .o_cycle_ev(o_cycle_ev),
    .o_cycle_point(o_cycle_point), .o_retrig_ev(o_retrig_ev),
    .o_wrap_ev(o_wrap_ev), .o_ch_ev_out(o_ch_ev_out),
    .o_cmd_retrigger(cmd[9]), .o_cmd_start(cmd[8]), .o_cmd_stop(cmd[7]),
    .o_cmd_count_event(cmd[6]), .o_cmd_count_gate(cmd[5]),
    .o_cmd_step_up(cmd[4]), .o_cmd_step_down(cmd[3]),
    .o_cmd_dir_down(cmd[2]), .o_cmd_ppw(cmd[1]), .o_cmd_pwp(cmd[0]),
    .o_fault_state(o_fault_state), .o_irq_enable(o_irq_enable),
    .i_wave(i_wave),
    .o_wave(o_wave), .o_wave_oe(o_wave_oe));

  // ======
  // Expected outputs one cycle after the stimulus
  function automatic logic [39:0] exp_ev(input logic [7:0] w,
      input logic [1:0] t, input logic [3:0] c, input logic [3:0] m,
      input logic [5:0] s, input logic h);
    logic [1:0] q;
    logic [2:0] a0;
    logic [2:0] a1;
    logic cp;
    q = (t ^ m_ev[13:12]) & m_ev[15:14];
    a0 = q[0] ? m_ev[2:0] : ACT_OFF;
    a1 = q[1] ? m_ev[5:3] : ACT_OFF;
    case (m_ev[7:6])
      SEL_BEGIN: cp = s[5];
      SEL_END: cp = s[4];
      SEL_BETWEEN: cp = s[4] & ~s[2];
      default: cp = (s[5] & s[3]) | (s[4] & s[2]);
    endcase
    return {flt ? m_drv[15:8] : w ^ m_drv[23:16],
      flt ? m_drv[7:0] : 8'hFF, m & m_ev[27:24], c & m_ev[19:16],
      cp & m_ev[10], cp, s[1] & m_ev[9], s[0] & m_ev[8],
      h & ~m_dbg[0], flt, a0 == ACT_RETRIG || a1 == ACT_RETRIG,
      a0 == ACT0_START, a1 == ACT1_STOP, a0 == ACT0_COUNT_ON_EVENT,
      a0 == ACT0_COUNT, a0 == ACT0_INC, a1 == ACT1_DEC, a1 == ACT1_DIR,
      a1 == ACT1_PPW, a1 == ACT1_PWP};
  endfunction

  // ======
  // Compare tasks and monitor
  task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %0t read %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp_ev(input logic [39:0] g, input logic [39:0] e,
      input logic [39:0] k);
    compares++;
    if ((g & k) !== (e & k)) begin
      failures++;
      $display("CHECK FAILED %0t outputs %h expected %h", $time, g, e);
    end
  endtask

  always @(posedge i_sys_clk) begin
    logic [31:0] e;
    rd_d <= i_rd;
    ra_d <= i_addr;
    chk_d <= chk;
    if (rd_d) begin
      e = rq.pop_front();
      cmp_rd(o_rdata, e);
      // Enable port must agree with the register view
      if (ra_d == ADDR_IEC || ra_d == ADDR_IES) begin
        cmp_rd(o_irq_enable, e);
      end
    end
    if (chk_d) begin
      cmp_ev(got, eq.pop_front(), mq.pop_front());
    end
  end

  // ======
  // Drivers
  // Next task lowers the strobe, so accesses may abut
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    chk <= 1'b0;
    i_addr <= a;
    i_wdata <= d;
    i_rd <= 1'b0;
    i_wr <= 1'b1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_sys_clk);
    chk <= 1'b0;
    i_addr <= a;
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    rq.push_back(e);
  endtask

  task automatic idle(input int n);
    @(posedge i_sys_clk);
    chk <= 1'b0;
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    repeat (n) @(posedge i_sys_clk);
  endtask

  task automatic cfg(input logic [31:0] d, input logic [31:0] e,
      input logic [7:0] g);
    wr(ADDR_DRV, d);
    wr(ADDR_EV, e);
    wr(ADDR_DBG, {24'h00_0000, g});
    m_drv = d;
    m_ev = e & EV_MASK;
    m_dbg = g & DBG_MASK;
  endtask

  task automatic step(input logic [1:0] t, input logic h);
    logic [7:0] w;
    logic [3:0] c;
    logic [3:0] m;
    logic [5:0] s;
    w = 8'($urandom);
    c = 4'($urandom);
    m = 4'($urandom);
    s = 6'($urandom);
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    i_wave <= w;
    tev_req <= t;
    ch_req <= c;
    i_cc_match <= m;
    cst <= s;
    i_debug_halt <= h;
    chk <= 1'b1;
    eq.push_back(exp_ev(w, t, c, m, s, h));
    // Undriven pins carry no defined level
    mq.push_back({flt ? m_drv[7:0] : 8'hFF, 32'hFFFF_FFFF});
  endtask

  task automatic end_of_test();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ======
  // Watchdog, the run needs under 2000 cycles
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    failures++;
    end_of_test();
  end

  // ======
  // Main sequence
  initial begin
    void'($urandom(32'h0000_a918));
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rd(ADDR_DRV, DRV_RST);
    rd(ADDR_DBG, {24'h00_0000, DBG_RST});
    rd(ADDR_EV, EV_RST);
    rd(ADDR_IEC, IEN_RST);
    rd(8'h04, 32'h0000_0000);
    cfg(32'hFFFF_FFFF, 32'hFFFF_FFFF, 8'hFF);
    rd(ADDR_DRV, 32'hFFFF_FFFF);
    rd(ADDR_DBG, {24'h00_0000, DBG_MASK});
    rd(ADDR_EV, EV_MASK);
    wr(ADDR_IES, 32'hFFFF_FFFF);
    rd(ADDR_IEC, IEN_MASK);
    wr(ADDR_IEC, 32'h0000_0000);
    rd(ADDR_IES, IEN_MASK);
    wr(ADDR_IEC, 32'h0005_4000);
    rd(ADDR_IEC, IEN_MASK & 32'hFFFA_BFFF);
    wr(ADDR_IEC, 32'h000A_8000);
    rd(ADDR_IES, IEN_MASK & 32'hFFF0_3FFF);
    i_wr_protect <= 1'b1;
    wr(ADDR_IES, 32'hFFFF_FFFF);
    wr(ADDR_DBG, 32'h0000_0000);
    rd(ADDR_IES, IEN_MASK & 32'hFFF0_3FFF);
    rd(ADDR_DBG, {24'h00_0000, DBG_MASK});
    i_wr_protect <= 1'b0;
    i_timer_enabled <= 1'b1;
    wr(ADDR_EV, 32'h0000_0000);
    wr(ADDR_DRV, 32'h0000_0000);
    rd(ADDR_EV, EV_MASK);
    rd(ADDR_DRV, 32'hFFFF_FFFF);
    i_timer_enabled <= 1'b0;
    idle(0);
    i_soft_reset <= 1'b1;
    idle(0);
    i_soft_reset <= 1'b0;
    rd(ADDR_DBG, {24'h00_0000, DBG_MASK});
    rd(ADDR_EV, EV_RST);
    rd(ADDR_DRV, DRV_RST);
    // Actions held below 7 so random traffic never latches a fault
    for (int i = 0; i < 8; i++) begin
      ev_r = $urandom & 32'hFFFF_FFC0;
      ev_r[2:0] = 3'($urandom_range(6));
      ev_r[5:3] = 3'($urandom_range(6));
      cfg($urandom, ev_r, {7'h00, 1'($urandom)});
      repeat (40) step(2'($urandom), 1'($urandom));
    end
    for (int a = 0; a < 7; a++) begin
      cfg(32'h0000_0000, 32'h0000_C000 | 32'(a) << 3 | 32'(a)
        | 32'(a[0]) << 12, 8'h00);
      repeat (4) step(2'($urandom), 1'b0);
    end
    cfg(32'h0030_050F, 32'h0000_0000, 8'h05);
    i_debug_halt <= 1'b1;
    idle(3);
    flt = 1'b1;
    repeat (6) step(2'($urandom), 1'b1);
    idle(0);
    i_debug_halt <= 1'b0;
    rd(ADDR_STS, 32'h0000_0004);
    wr(ADDR_STS, 32'h0000_0007);
    idle(2);
    flt = 1'b0;
    repeat (6) step(2'($urandom), 1'b0);
    idle(0);
    tev_req <= 2'h0;
    cfg(32'h0000_00F0, 32'h0000_5007, 8'h00);
    idle(3);
    flt = 1'b1;
    repeat (4) step(2'($urandom), 1'b0);
    rd(ADDR_STS, 32'h0000_0001);
    cfg(32'h0000_00F0, 32'h0000_0000, 8'h00);
    wr(ADDR_STS, 32'h0000_0007);
    idle(2);
    flt = 1'b0;
    repeat (4) step(2'($urandom), 1'b0);
    idle(2);
    end_of_test();
  end
endmodule
